//--- verification/adc_window_compare_tb_top.sv
// Purpose: Self-checking bench for the converter window detector
// Assumes: Reads answer one cycle later; the flag lands one cycle after a result
// Notes: Limits are written byte by byte, as the port has no pairing latch
`timescale 1ns/1ps
module adc_window_compare_tb_top;
    import window_pkg::*;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    conv_result_s result_in = '0;
    reg_req_s req_in = '0;
    logic [7:0] rdata_out;
    logic window_match_flag_out;
    logic irq_out;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    adc_window_compare i_dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .result_in(result_in), .req_in(req_in), .rdata_out(rdata_out),
        .window_match_flag_out(window_match_flag_out), .irq_out(irq_out));
    initial begin
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    // ---------------------------------------------------------------
    // Hang guard: the whole run needs well under a thousand cycles
    // ---------------------------------------------------------------
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // ---------------------------------------------------------------
    // Port drivers
    // ---------------------------------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_in);
        req_in.wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk_in);
        req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_in);
        req_in.rd <= 1'b0;
        #1 chk(what, exp, rdata_out);
    endtask
    task automatic set_lim(input logic [15:0] up, input logic [15:0] lo);
        reg_wr(upper_high_off, up[15:8]);
        reg_wr(upper_low_off, up[7:0]);
        reg_wr(lower_high_off, lo[15:8]);
        reg_wr(lower_low_off, lo[7:0]);
    endtask
    // Clears both control flags first, so a stale flag cannot pass for a match
    task automatic send(input logic [15:0] d, input logic exp);
        reg_wr(ctrl_off, 8'h28);
        @(posedge ref_clk_in);
        result_in <= '{valid: 1'b1, data: d};
        @(posedge ref_clk_in);
        result_in.valid <= 1'b0;
        #1 chk("window flag", {7'h00, exp}, {7'h00, window_match_flag_out});
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_regs();
        reg_rd(upper_low_off, 8'hff, "upper low reset");
        reg_rd(upper_high_off, 8'hff, "upper high reset");
        reg_rd(lower_low_off, 8'h00, "lower low reset");
        reg_wr(upper_low_off, 8'h5a);
        reg_rd(upper_low_off, 8'h5a, "upper low readback");
        reg_wr(8'h00, 8'h77);
        reg_rd(8'h00, 8'h00, "unmapped read");
        reg_wr(upper_low_off, 8'hff);
    endtask
    task automatic t_outside();
        send(16'h0000, 1'b0);
        send(16'hffff, 1'b0);
        set_lim(16'h0100, 16'h0010);
        send(16'h0005, 1'b1);
        send(16'h0010, 1'b0);
        send(16'h0050, 1'b0);
        send(16'h0100, 1'b0);
        send(16'h0101, 1'b1);
    endtask
    task automatic t_inside();
        set_lim(16'h0100, 16'h0200);
        send(16'h0100, 1'b0);
        send(16'h0101, 1'b1);
        send(16'h01ff, 1'b1);
        send(16'h0200, 1'b0);
        send(16'h0050, 1'b0);
    endtask
    task automatic t_irq();
        reg_wr(mask_off, 8'h08);
        send(16'h0150, 1'b1);
        reg_rd(ctrl_off, 8'h28, "control flags");
        chk("irq", 8'h01, {7'h00, irq_out});
        reg_rd(result_high_off, 8'h01, "result high");
        reg_rd(result_low_off, 8'h50, "result low");
        reg_wr(result_low_off, 8'haa);
        reg_rd(result_low_off, 8'h50, "result read-only");
        reg_wr(mask_off, 8'h00);
        @(posedge ref_clk_in);
        #1 chk("masked irq", 8'h00, {7'h00, irq_out});
        chk("standing flag", 8'h01, {7'h00, window_match_flag_out});
        reg_wr(mask_off, 8'h08);
        reg_wr(ctrl_off, 8'h08);
        @(posedge ref_clk_in);
        #1 chk("cleared irq", 8'h00, {7'h00, irq_out});
        reg_rd(ctrl_off, 8'h20, "control after clear");
    endtask
    // Clear and matching result on one edge: the hardware set must win
    task automatic t_race();
        @(posedge ref_clk_in);
        req_in <= '{addr: ctrl_off, wdata: 8'h28, wr: 1'b1, rd: 1'b0};
        result_in <= '{valid: 1'b1, data: 16'h0150};
        @(posedge ref_clk_in);
        req_in.wr <= 1'b0;
        result_in.valid <= 1'b0;
        #1 chk("flag on clear race", 8'h01, {7'h00, window_match_flag_out});
        reg_rd(ctrl_off, 8'h28, "control after race");
    endtask
    // Reset in mid-run with the flag and interrupt standing
    task automatic t_reset();
        reg_wr(upper_low_off, 8'h12);
        @(posedge ref_clk_in);
        nrst_in <= 1'b0;
        @(posedge ref_clk_in);
        #1 chk("flag in reset", 8'h00, {7'h00, window_match_flag_out});
        chk("irq in reset", 8'h00, {7'h00, irq_out});
        @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        reg_rd(upper_low_off, 8'hff, "upper low after reset");
        reg_rd(mask_off, 8'h00, "mask after reset");
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        t_regs();
        t_outside();
        t_inside();
        t_irq();
        t_race();
        t_reset();
        test_done();
    end
endmodule // adc_window_compare_tb_top

//--- verilog/adc_window_compare.sv
// Purpose: Window detector beside the converter, with its limit registers
// Assumes: One result per cycle at most, marked by its valid bit
// Notes: Flag lives in the converter control register and drives an interrupt
// Operation
// - Every new result is compared to the limits by hardware alone.
// - A match sets the window flag in the control register; poll or interrupt.
// - Upper and lower limits each have a high and a low byte register.
// - Limit ordering selects inside-window or outside-window detection.
// - Upper limit low byte is read/write and resets to all ones.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module adc_window_compare (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire window_pkg::conv_result_s result_in,
    input wire window_pkg::reg_req_s req_in,
    output logic [7:0] rdata_out,
    output logic window_match_flag_out,
    output logic irq_out
);
    import window_pkg::*;

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic [7:0] upper_high_q, upper_high_d;
    logic [7:0] upper_low_q, upper_low_d;
    logic [7:0] lower_high_q, lower_high_d;
    logic [7:0] lower_low_q, lower_low_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] mask_q, mask_d;
    logic [15:0] result_q, result_d;
    logic [7:0] rdata_q, rdata_d;
    logic match;
    logic done;

    // Compare runs on the live result, so the flag lands one cycle after valid
    window_compare #(
        .W(16)
    ) u_cmp (
        .result_in(result_in.data),
        .upper_in({upper_high_q, upper_low_q}),
        .lower_in({lower_high_q, lower_low_q}),
        .match_out(match)
    );

    assign done = result_in.valid;

    always_comb begin
        upper_high_d = upper_high_q;
        upper_low_d = upper_low_q;
        lower_high_d = lower_high_q;
        lower_low_d = lower_low_q;
        mask_d = mask_q;
        ctrl_d = ctrl_q;
        result_d = result_q;
        rdata_d = 8'h00;
        // ---------------------------------------------------------------
        // Writes; flag bits clear by writing one
        // ---------------------------------------------------------------
        // Result addresses are absent here, so writes to them are dropped
        if (req_in.wr) begin
            if (req_in.addr == upper_high_off) begin
                upper_high_d = req_in.wdata;
            end else if (req_in.addr == upper_low_off) begin
                upper_low_d = req_in.wdata;
            end else if (req_in.addr == lower_high_off) begin
                lower_high_d = req_in.wdata;
            end else if (req_in.addr == lower_low_off) begin
                lower_low_d = req_in.wdata;
            end else if (req_in.addr == mask_off) begin
                mask_d = req_in.wdata;
            end else if (req_in.addr == ctrl_off) begin
                // Only flag bits ever hold a one, so the whole byte is write-one-to-clear
                ctrl_d = ctrl_q & ~req_in.wdata;
            end
        end
        // Hardware set wins over a clear in the same cycle
        if (done) begin
            result_d = result_in.data;
            ctrl_d[done_bit] = 1'b1;
            if (match) begin
                ctrl_d[win_bit] = 1'b1;
            end
        end
        // ---------------------------------------------------------------
        // Reads; unmapped addresses return zero
        // ---------------------------------------------------------------
        if (req_in.rd) begin
            if (req_in.addr == upper_high_off) begin
                rdata_d = upper_high_q;
            end else if (req_in.addr == upper_low_off) begin
                rdata_d = upper_low_q;
            end else if (req_in.addr == lower_high_off) begin
                rdata_d = lower_high_q;
            end else if (req_in.addr == lower_low_off) begin
                rdata_d = lower_low_q;
            end else if (req_in.addr == mask_off) begin
                rdata_d = mask_q;
            end else if (req_in.addr == ctrl_off) begin
                rdata_d = ctrl_q;
            end else if (req_in.addr == result_high_off) begin
                rdata_d = result_q[15:8];
            end else if (req_in.addr == result_low_off) begin
                rdata_d = result_q[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            upper_high_q <= upper_high_rst;
            upper_low_q <= upper_low_rst;
            lower_high_q <= lower_high_rst;
            lower_low_q <= lower_low_rst;
            ctrl_q <= ctrl_rst;
            mask_q <= mask_rst;
            result_q <= result_rst;
            rdata_q <= 8'h00;
        end else begin
            upper_high_q <= upper_high_d;
            upper_low_q <= upper_low_d;
            lower_high_q <= lower_high_d;
            lower_low_q <= lower_low_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            result_q <= result_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;
    assign window_match_flag_out = ctrl_q[win_bit];
    // The done flag interrupts too when its mask bit is set
    assign irq_out = |(ctrl_q & mask_q);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_flag_on_match: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (result_in.valid && match) |=> ctrl_q[win_bit])
        else $error("window flag not set after matching result");
    a_flag_sticky: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (ctrl_q[win_bit] && !(req_in.wr && req_in.addr == ctrl_off
            && req_in.wdata[win_bit])) |=> ctrl_q[win_bit])
        else $error("window flag dropped without a clear");
    a_flag_no_cause: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (!ctrl_q[win_bit] && !(result_in.valid && match)) |=> !ctrl_q[win_bit])
        else $error("window flag set without a match");
    a_upper_low_write: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (req_in.wr && req_in.addr == upper_low_off)
            |=> upper_low_q == $past(req_in.wdata))
        else $error("upper low byte write lost");
    a_lower_high_write: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (req_in.wr && req_in.addr == lower_high_off)
            |=> lower_high_q == $past(req_in.wdata))
        else $error("lower high byte write lost");
    a_upper_low_read: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (req_in.rd && req_in.addr == upper_low_off && !req_in.wr)
            |=> rdata_out == $past(upper_low_q))
        else $error("upper low byte read mismatch");
    a_inside_mode: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        ({lower_high_q, lower_low_q} > {upper_high_q, upper_low_q} && result_in.valid
            && result_in.data < {upper_high_q, upper_low_q}) |-> !match)
        else $error("inside mode matched a result below the window");
    a_outside_mode: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        ({lower_high_q, lower_low_q} <= {upper_high_q, upper_low_q} && result_in.valid
            && result_in.data > {upper_high_q, upper_low_q}) |-> match)
        else $error("outside mode missed a result above upper limit");
    a_irq_level: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (ctrl_q[win_bit] && mask_q[win_bit]) |-> irq_out)
        else $error("interrupt not raised for unmasked window flag");
    // ---------------------------------------------------------------
    // Limit register checks
    // ---------------------------------------------------------------
    a_upper_high_write: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (req_in.wr && req_in.addr == upper_high_off)
            |=> upper_high_q == $past(req_in.wdata))
        else $error("upper high byte write lost");
    a_lower_low_write: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (req_in.wr && req_in.addr == lower_low_off)
            |=> lower_low_q == $past(req_in.wdata))
        else $error("lower low byte write lost");
    // A limit must not drift between writes, or the window moves under software
    a_limit_hold: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (!(req_in.wr && req_in.addr == upper_low_off))
            |=> upper_low_q == $past(upper_low_q))
        else $error("upper low byte changed without a write");
    // ---------------------------------------------------------------
    // Compare, flag, result capture, interrupt and control read checks
    // ---------------------------------------------------------------
    a_inside_between: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        ({lower_high_q, lower_low_q} > {upper_high_q, upper_low_q} && result_in.valid
            && result_in.data > {upper_high_q, upper_low_q}
            && result_in.data < {lower_high_q, lower_low_q}) |-> match)
        else $error("inside mode missed a result between the limits");
    a_outside_below: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        ({lower_high_q, lower_low_q} <= {upper_high_q, upper_low_q} && result_in.valid
            && result_in.data < {lower_high_q, lower_low_q}) |-> match)
        else $error("outside mode missed a result below lower limit");
    a_outside_between: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        ({lower_high_q, lower_low_q} <= {upper_high_q, upper_low_q} && result_in.valid
            && result_in.data >= {lower_high_q, lower_low_q}
            && result_in.data <= {upper_high_q, upper_low_q}) |-> !match)
        else $error("outside mode matched a result inside the limits");
    a_result_capture: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        result_in.valid |=> result_q == $past(result_in.data))
        else $error("result not captured");
    a_done_flag_set: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        result_in.valid |=> ctrl_q[done_bit])
        else $error("done flag not set after a result");
    a_flag_clear: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (req_in.wr && req_in.addr == ctrl_off && req_in.wdata[win_bit]
            && !(result_in.valid && match)) |=> !ctrl_q[win_bit])
        else $error("window flag survived a write-one clear");
    a_set_beats_clear: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (req_in.wr && req_in.addr == ctrl_off && result_in.valid && match)
            |=> ctrl_q[win_bit])
        else $error("clear in the same cycle beat a matching result");
    a_irq_quiet: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (!ctrl_q[win_bit] && !ctrl_q[done_bit]) |-> !irq_out)
        else $error("interrupt raised with no flag set");
    a_ctrl_read: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (req_in.rd && req_in.addr == ctrl_off) |=> rdata_out == $past(ctrl_q))
        else $error("control register read mismatch");
endmodule // adc_window_compare

//--- verilog/window_compare.sv
// Purpose: Pure compare of one result against the two limits
// Assumes: Limits and result are unsigned words of the same width
// Notes: Combinational; the caller registers the outcome
`timescale 1ns/1ps
module window_compare #(
    parameter int W = 16
) (
    input wire logic [W-1:0] result_in,
    input wire logic [W-1:0] upper_in,
    input wire logic [W-1:0] lower_in,
    output logic match_out
);
    always_comb begin
        if (lower_in > upper_in) begin
            // Inside window: strictly between the limits
            match_out = (result_in > upper_in) && (result_in < lower_in);
        end else begin
            // Outside window: below lower or above upper
            match_out = (result_in < lower_in) || (result_in > upper_in);
        end
    end
endmodule // window_compare

//--- verilog/window_pkg.sv
// Purpose: Constants and types for the converter window comparison block
// Assumes: 8-bit register port, 10-bit conversion results right justified
// Notes: Register offsets sit in the special function address space
package window_pkg;
    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ctrl_off = 8'he8;
    localparam logic [7:0] upper_high_off = 8'hc4;
    localparam logic [7:0] upper_low_off = 8'hc3;
    localparam logic [7:0] lower_high_off = 8'hc6;
    localparam logic [7:0] lower_low_off = 8'hc5;
    localparam logic [7:0] result_high_off = 8'hbe;
    localparam logic [7:0] result_low_off = 8'hbd;
    localparam logic [7:0] mask_off = 8'hc7;
    // ---------------------------------------------------------------
    // Reset values and field positions
    // ---------------------------------------------------------------
    localparam logic [7:0] upper_high_rst = 8'hff;
    localparam logic [7:0] upper_low_rst = 8'hff;
    localparam logic [7:0] lower_high_rst = 8'h00;
    localparam logic [7:0] lower_low_rst = 8'h00;
    localparam logic [7:0] ctrl_rst = 8'h00;
    localparam logic [7:0] mask_rst = 8'h00;
    localparam logic [15:0] result_rst = 16'h0000;
    localparam int win_bit = 3;
    localparam int done_bit = 5;
    localparam int result_w = 10;
    // Result sample as it arrives from the converter
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } conv_result_s;
    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
endpackage
